// *** ascf_pkg.sv ***
// Shared constants for the converter scan, compare-hit and result-format block.
package ascf_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] ADDR_CONTROL = 8'h00;      // Converter control word.
  localparam logic [7:0] ADDR_HIT_LOW = 8'h04;      // Compare hits, channels 15..0.
  localparam logic [7:0] ADDR_HIT_HIGH = 8'h08;     // Compare hits, channels 17..16.
  localparam logic [7:0] ADDR_SCAN_LOW = 8'h0c;     // Scan selects, channels 15..0.
  localparam logic [7:0] ADDR_SCAN_HIGH = 8'h10;    // Scan selects, upper channels.
  localparam logic [7:0] ADDR_CONN_LOW = 8'h14;     // Charge unit connects, 15..0.
  localparam logic [7:0] ADDR_CONN_HIGH = 8'h18;    // Charge unit connects, 17..16.
  localparam logic [7:0] ADDR_RESULT = 8'h1c;       // Last formatted result.
  localparam logic [7:0] ADDR_STATUS = 8'h20;       // Sticky event flags.
  localparam logic [7:0] ADDR_MASK = 8'h24;         // Interrupt mask.
  localparam logic [7:0] ADDR_STATE = 8'h28;        // Sequencer state and channel.

  ////////////////////////////////////////////////////////////////////////////////
  // Control word field positions.
  localparam int CTL_START = 0;                     // Write one to start a scan.
  localparam int CTL_OUTPUT_FORMAT_LO = 8;                   // Output format, two bits.
  localparam int CTL_RES = 10;                      // Resolution select.
  localparam int CTL_CM_LO = 12;                    // Compare mode, two bits.
  localparam int CTL_DIV_LO = 16;                   // Conversion clock divider.
  localparam int CTL_SAMP_LO = 24;                  // Sample time in conversion periods.
  localparam logic [31:0] CTL_WMASK = 32'h1fff_3700; // Stored control bits.

  // Implemented bits of the upper words; all other bits read as zero.
  localparam logic [15:0] HIT_HIGH_IMPL = 16'h0003;
  localparam logic [15:0] SCAN_HIGH_IMPL = 16'h7c03;
  localparam logic [15:0] CONN_HIGH_IMPL = 16'h0003;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // Channel numbering.
  localparam int NUM_CHAN = 32;                     // Width of the scan map.
  localparam int NUM_HIT = 18;                      // Channels with hit/connect bits.

  // Compare mode and output format encodings.
  localparam logic [1:0] CM_OUTSIDE = 2'h3;
  typedef enum logic [1:0] {
    ASCF_OUTPUT_FORMAT_INT, ASCF_OUTPUT_FORMAT_SINT, ASCF_OUTPUT_FORMAT_FRAC, ASCF_OUTPUT_FORMAT_SFRAC
  } ascf_output_format_t;

  // Code limits for 12-bit and 10-bit resolution.
  localparam logic signed [15:0] MAX12 = 16'sh0fff;
  localparam logic signed [15:0] MIN12 = -16'sh1000;
  localparam logic signed [15:0] MAX10 = 16'sh03ff;
  localparam logic signed [15:0] MIN10 = -16'sh0400;

  // Status bits.
  localparam int ST_RESULT = 0;                     // A result was stored.
  localparam int ST_HIT = 1;                        // A compare hit was set.
  localparam int ST_DONE = 2;                       // A scan pass completed.
  localparam int ST_W = 3;

  // Timing: hclk is the oscillator; an instruction cycle is two of its periods.
  localparam int CLK_PERIOD_NS = 100;
  localparam int TCY_NS = 2 * CLK_PERIOD_NS;
  localparam int TCY_CLKS = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// *** ascf_core.sv ***
`timescale 1ns/10ps
// Function
// - Outside mode: hit on buffer write or match.
// - Other modes: hit only on valid match.
// - Unimplemented hit/scan/connect bits read zero.
// - Upper scan word bits 14-10, 1-0 map.
// - Lower scan word bit n selects input n.
// - Connect bit 17/16 enables charge unit while converting.
// - Lower connect bits apply same per channel.
// - Full discharged sample precedes every conversion.
// - Conversion period is instruction cycle times divider+1.
// - One LSb is reference span over 4096.
// - Unsigned codes saturate at all-zero and all-ones; signed codes at the signed min and max.
// - Resolution select picks 12 or 10 bits.
// - Signed integer extends sign bit to 16; signed fraction is left-justified.
// - Output format field at control bits 9:8.
module ascf_core (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave port.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Converter front end.
  output logic [4:0] adc_channel,
  output logic adc_sample,
  output logic adc_hold_discharge,
  output logic adc_convert_start,
  output logic charge_unit_enable,
  input wire logic adc_done,
  input wire logic signed [15:0] adc_value,
  input wire logic adc_match,
  // Interrupt.
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Clamps a raw value to the code range.
  function automatic logic [12:0] saturate(input logic signed [15:0] v, input logic res12,
                                           input logic signed_fmt);
    logic signed [15:0] hi;
    logic signed [15:0] lo;
    logic signed [15:0] c;
    hi = res12 ? ascf_pkg::MAX12 : ascf_pkg::MAX10;
    lo = signed_fmt ? (res12 ? ascf_pkg::MIN12 : ascf_pkg::MIN10) : 16'sh0000;
    c = v;
    if (v > hi) begin
      c = hi;
    end else if (v < lo) begin
      c = lo;
    end
    return c[12:0];
  endfunction

  // Places a code in the word for the format.
  function automatic logic [15:0] place(input logic [12:0] c, input logic res12,
                                        input ascf_pkg::ascf_output_format_t f);
    logic [15:0] w;
    w = 16'h0000;
    if (res12) begin
      unique case (f)
        ascf_pkg::ASCF_OUTPUT_FORMAT_INT: w = {4'h0, c[11:0]};
        ascf_pkg::ASCF_OUTPUT_FORMAT_SINT: w = {{3{c[12]}}, c[12:0]};
        ascf_pkg::ASCF_OUTPUT_FORMAT_FRAC: w = {c[11:0], 4'h0};
        ascf_pkg::ASCF_OUTPUT_FORMAT_SFRAC: w = {c[12:0], 3'h0};
      endcase
    end else begin
      unique case (f)
        ascf_pkg::ASCF_OUTPUT_FORMAT_INT: w = {6'h00, c[9:0]};
        ascf_pkg::ASCF_OUTPUT_FORMAT_SINT: w = {{5{c[10]}}, c[10:0]};
        ascf_pkg::ASCF_OUTPUT_FORMAT_FRAC: w = {c[9:0], 6'h00};
        ascf_pkg::ASCF_OUTPUT_FORMAT_SFRAC: w = {c[10:0], 5'h00};
      endcase
    end
    return w;
  endfunction

  // Finds the lowest selected channel above a position.
  function automatic logic [5:0] next_chan(input logic [31:0] map, input logic [5:0] after);
    logic [5:0] r;
    r = 6'h20;
    for (int i = ascf_pkg::NUM_CHAN - 1; i >= 0; i--) begin
      if (map[i] && (6'(i) > after || after == 6'h3f)) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  typedef enum logic [1:0] {ASCF_IDLE, ASCF_SAMPLE, ASCF_CONVERT} ascf_state_t;

  // Bus pipeline registers.
  logic wr_pend;            // Write data phase is pending.
  logic [7:0] wr_addr;      // Offset of the pending write.
  logic next_wr_pend;
  logic [7:0] next_wr_addr;
  logic [31:0] next_hrdata;

  // Software registers.
  logic [31:0] control;     // Stored control fields.
  logic [17:0] hit;         // Compare-hit flags.
  logic [31:0] scan_map;    // Scan selects by channel.
  logic [17:0] connect;     // Charge unit connects by channel.
  logic [15:0] result;      // Last formatted result.
  logic [ascf_pkg::ST_W-1:0] status;
  logic [ascf_pkg::ST_W-1:0] mask;
  logic [31:0] next_control;
  logic [17:0] next_hit;
  logic [31:0] next_scan_map;
  logic [17:0] next_connect;
  logic [15:0] next_result;
  logic [ascf_pkg::ST_W-1:0] next_status;
  logic [ascf_pkg::ST_W-1:0] next_mask;
  logic next_irq;
  logic start_req;          // Software wrote the start bit.

  // Sequencer.
  ascf_state_t state;
  ascf_state_t next_state;
  logic [5:0] chan;         // Current channel.
  logic [5:0] next_chan_q;
  logic [9:0] clk_cnt;      // Cycles within a period.
  logic [9:0] next_clk_cnt;
  logic [5:0] tad_cnt;      // Periods spent sampling.
  logic [5:0] next_tad_cnt;
  logic [9:0] tad_last;     // Last count of a period.
  logic tad_tick;           // Enable at each period end.
  logic [5:0] samp_need;    // Sample periods, at least one.
  logic [5:0] following;    // Next selected channel.
  logic store_evt;          // Result stored this cycle.
  logic done_evt;           // Scan pass finished this cycle.
  logic [17:0] hit_set;     // Hit flags raised this cycle.
  logic next_sample;
  logic next_discharge;
  logic next_conv_start;
  logic next_charge_en;

  // Control field views.
  ascf_pkg::ascf_output_format_t output_format;
  logic res12;
  logic [1:0] cmp_mode;
  logic [7:0] clk_div;
  logic [4:0] samp_time;

  assign output_format = ascf_pkg::ascf_output_format_t'(control[ascf_pkg::CTL_OUTPUT_FORMAT_LO +: 2]);
  assign res12 = control[ascf_pkg::CTL_RES];
  assign cmp_mode = control[ascf_pkg::CTL_CM_LO +: 2];
  assign clk_div = control[ascf_pkg::CTL_DIV_LO +: 8];
  assign samp_time = control[ascf_pkg::CTL_SAMP_LO +: 5];

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: no wait states, always OKAY.
  // Read data is set up in the address phase.
  always_comb begin
    logic take;
    logic [7:0] a;
    take = hsel && htrans[1] && hready;
    a = haddr[7:0];
    next_wr_pend = take && hwrite;
    next_wr_addr = take ? a : wr_addr;
    next_hrdata = 32'h0000_0000;
    if (take && !hwrite) begin
      unique case (a)
        ascf_pkg::ADDR_CONTROL: next_hrdata = control;
        // Unimplemented bits read zero.
        ascf_pkg::ADDR_HIT_LOW: next_hrdata = {16'h0000, hit[15:0]};
        ascf_pkg::ADDR_HIT_HIGH: next_hrdata = {30'h0, hit[17:16]};
        ascf_pkg::ADDR_SCAN_LOW: next_hrdata = {16'h0000, scan_map[15:0]};
        ascf_pkg::ADDR_SCAN_HIGH: next_hrdata = {17'h0, scan_map[30:26], 8'h00,
                                                 scan_map[17:16]};
        ascf_pkg::ADDR_CONN_LOW: next_hrdata = {16'h0000, connect[15:0]};
        ascf_pkg::ADDR_CONN_HIGH: next_hrdata = {30'h0, connect[17:16]};
        ascf_pkg::ADDR_RESULT: next_hrdata = {16'h0000, result};
        ascf_pkg::ADDR_STATUS: next_hrdata = {29'h0, status};
        ascf_pkg::ADDR_MASK: next_hrdata = {29'h0, mask};
        ascf_pkg::ADDR_STATE: next_hrdata = {16'h0000, 6'h00, state, 2'h0, chan};
        default: next_hrdata = 32'h0000_0000; // Unmapped offsets read zero.
      endcase
    end
  end

  // Registers the bus pipeline.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers, sticky flags and interrupt.
  // A hardware set beats a write or clear.
  always_comb begin
    logic [15:0] d;
    d = hwdata[15:0];
    next_control = control;
    next_hit = hit;
    next_scan_map = scan_map;
    next_connect = connect;
    next_mask = mask;
    next_status = status;
    next_result = result;
    start_req = 1'b0;
    if (wr_pend) begin
      unique case (wr_addr)
        ascf_pkg::ADDR_CONTROL: begin
          next_control = hwdata & ascf_pkg::CTL_WMASK;
          start_req = hwdata[ascf_pkg::CTL_START];
        end
        ascf_pkg::ADDR_HIT_LOW: next_hit[15:0] = d;
        ascf_pkg::ADDR_HIT_HIGH: next_hit[17:16] = d[1:0] & ascf_pkg::HIT_HIGH_IMPL[1:0];
        ascf_pkg::ADDR_SCAN_LOW: next_scan_map[15:0] = d;
        ascf_pkg::ADDR_SCAN_HIGH: begin
          // Upper channels 30..26 and 17..16 only.
          next_scan_map[30:26] = d[14:10] & ascf_pkg::SCAN_HIGH_IMPL[14:10];
          next_scan_map[17:16] = d[1:0] & ascf_pkg::SCAN_HIGH_IMPL[1:0];
        end
        ascf_pkg::ADDR_CONN_LOW: next_connect[15:0] = d;
        ascf_pkg::ADDR_CONN_HIGH: next_connect[17:16] = d[1:0] & ascf_pkg::CONN_HIGH_IMPL[1:0];
        ascf_pkg::ADDR_STATUS: next_status = status & ~d[ascf_pkg::ST_W-1:0];
        ascf_pkg::ADDR_MASK: next_mask = d[ascf_pkg::ST_W-1:0];
        default: next_mask = mask; // Writes elsewhere are ignored.
      endcase
    end
    next_hit = next_hit | hit_set;
    if (store_evt) begin
      next_result = place(saturate(adc_value, res12, output_format[0]), res12, output_format);
      next_status[ascf_pkg::ST_RESULT] = 1'b1;
    end
    if (|hit_set) begin
      next_status[ascf_pkg::ST_HIT] = 1'b1;
    end
    if (done_evt) begin
      next_status[ascf_pkg::ST_DONE] = 1'b1;
    end
    next_irq = |(next_status & next_mask);
  end

  // Registers the software-visible state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control <= 32'h0000_0000;
      hit <= 18'h00000;
      scan_map <= {2{ascf_pkg::RESET_WORD}};
      connect <= 18'h00000;
      result <= 16'h0000;
      status <= 3'h0;
      mask <= 3'h0;
      irq <= 1'b0;
    end else begin
      control <= next_control;
      hit <= next_hit;
      scan_map <= next_scan_map;
      connect <= next_connect;
      result <= next_result;
      status <= next_status;
      mask <= next_mask;
      irq <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Scan sequencer: per channel a discharged sample of
  // at least one period, then a conversion.
  assign tad_last = 10'((32'(clk_div) + 1) * ascf_pkg::TCY_CLKS - 1);
  assign tad_tick = (clk_cnt == tad_last);
  assign samp_need = (samp_time == 5'h00) ? 6'h01 : {1'b0, samp_time};
  assign following = next_chan(scan_map, chan);

  always_comb begin
    next_state = state;
    next_chan_q = chan;
    next_clk_cnt = tad_tick ? 10'h000 : 10'(clk_cnt + 10'h001);
    next_tad_cnt = tad_cnt;
    store_evt = 1'b0;
    done_evt = 1'b0;
    hit_set = 18'h00000;
    next_discharge = 1'b0;
    next_conv_start = 1'b0;
    unique case (state)
      ASCF_IDLE: begin
        next_clk_cnt = 10'h000;
        if (start_req) begin
          next_chan_q = next_chan(scan_map, 6'h3f);
          if (next_chan_q[5]) begin
            done_evt = 1'b1; // Empty map: the pass ends at once.
            next_chan_q = chan;
          end else begin
            next_state = ASCF_SAMPLE;
            next_tad_cnt = 6'h00;
            next_discharge = 1'b1;
          end
        end
      end
      ASCF_SAMPLE: begin
        if (tad_tick) begin
          next_tad_cnt = 6'(tad_cnt + 6'h01);
          if (6'(tad_cnt + 6'h01) >= samp_need) begin
            next_state = ASCF_CONVERT;
            next_conv_start = 1'b1;
          end
        end
      end
      ASCF_CONVERT: begin
        next_clk_cnt = 10'h000;
        if (adc_done) begin
          store_evt = 1'b1;
          if (chan < 6'(ascf_pkg::NUM_HIT)) begin
            if (cmp_mode == ascf_pkg::CM_OUTSIDE) begin
              hit_set[chan[4:0]] = 1'b1;
            end else if (adc_match) begin
              hit_set[chan[4:0]] = 1'b1;
            end
          end
          if (following[5]) begin
            next_state = ASCF_IDLE;
            done_evt = 1'b1;
          end else begin
            next_state = ASCF_SAMPLE;
            next_chan_q = following;
            next_tad_cnt = 6'h00;
            next_discharge = 1'b1;
          end
        end
      end
    endcase
    next_sample = (next_state == ASCF_SAMPLE);
    next_charge_en = (next_state == ASCF_CONVERT) && (next_chan_q < 6'(ascf_pkg::NUM_HIT))
                     && connect[next_chan_q[4:0]];
  end

  // Registers the sequencer and its front-end outputs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ASCF_IDLE;
      chan <= 6'h00;
      clk_cnt <= 10'h000;
      tad_cnt <= 6'h00;
      adc_channel <= 5'h00;
      adc_sample <= 1'b0;
      adc_hold_discharge <= 1'b0;
      adc_convert_start <= 1'b0;
      charge_unit_enable <= 1'b0;
    end else begin
      state <= next_state;
      chan <= next_chan_q;
      clk_cnt <= next_clk_cnt;
      tad_cnt <= next_tad_cnt;
      adc_channel <= next_chan_q[4:0];
      adc_sample <= next_sample;
      adc_hold_discharge <= next_discharge;
      adc_convert_start <= next_conv_start;
      charge_unit_enable <= next_charge_en;
    end
  end

endmodule

// *** ascf_core_assertions.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Checks the sequencer outputs and the bus answer.
module ascf_core_checker (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Bus answer.
  input wire logic hreadyout,
  input wire logic hresp,
  // Front end.
  input wire logic [4:0] adc_channel,
  input wire logic adc_sample,
  input wire logic adc_hold_discharge,
  input wire logic adc_convert_start,
  input wire logic charge_unit_enable
);
  // All checks share the bus clock and reset.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // The slave never stalls and always answers OKAY.
  a_bus_ready_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  // The hold capacitor is discharged only while sampling.
  a_discharge_in_sample: assert property (adc_hold_discharge |-> adc_sample)
    else $error("discharge outside sampling");
  // Each sample opens with the capacitor discharged.
  a_sample_opens_discharged: assert property ($rose(adc_sample) |-> adc_hold_discharge)
    else $error("sample without discharge");
  // Discharge and convert strobes last one cycle.
  a_discharge_one_cycle: assert property (adc_hold_discharge |=> !adc_hold_discharge)
    else $error("discharge pulse too long");
  a_convert_one_cycle: assert property (adc_convert_start |=> !adc_convert_start)
    else $error("convert pulse too long");
  // Conversion starts only as a full sampling phase ends.
  a_convert_after_sample: assert property (
    adc_convert_start |-> !adc_sample && $past(adc_sample))
    else $error("convert without sampling");
  // The shortest sample is one period of two clocks.
  a_sample_min_length: assert property ($rose(adc_sample) |-> adc_sample [*2])
    else $error("sample too short");
  // The channel holds while a sample is in progress.
  a_channel_held: assert property (
    adc_sample && $past(adc_sample) |-> $stable(adc_channel))
    else $error("channel moved in sample");
  // Only implemented channels are ever sampled.
  a_channel_legal: assert property (adc_sample |->
    (adc_channel < 5'h12) || (adc_channel >= 5'h1a && adc_channel <= 5'h1e))
    else $error("bad channel sampled");
  // The charge unit is on only outside sampling, on a channel below 18.
  a_charge_unit_gate: assert property (
    charge_unit_enable |-> !adc_sample && adc_channel < 5'h12)
    else $error("charge unit misplaced");
endmodule

bind ascf_core ascf_core_checker ascf_core_checker_inst (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .adc_channel(adc_channel), .adc_sample(adc_sample),
  .adc_hold_discharge(adc_hold_discharge), .adc_convert_start(adc_convert_start),
  .charge_unit_enable(charge_unit_enable)
);

// *** ascf_fe_model.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Front end model: answers each conversion after a set delay.
module ascf_fe_model (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Sequencer strobes.
  input wire logic adc_sample,
  input wire logic adc_convert_start,
  // Value, match and delay chosen by the bench.
  input wire logic signed [15:0] value_in,
  input wire logic match_in,
  input wire logic [3:0] delay_in,
  // Answer to the sequencer.
  output logic adc_done,
  output logic signed [15:0] adc_value,
  output logic adc_match
);
  logic [3:0] cnt; // Cycles left until the answer.
  logic [3:0] next_cnt;

  // A conversion begins only once sampling has ended.
  always_comb begin
    next_cnt = cnt;
    if (adc_convert_start && !adc_sample) begin
      next_cnt = (delay_in == 4'h0) ? 4'h1 : delay_in;
    end else if (cnt != 4'h0) begin
      next_cnt = cnt - 4'h1;
    end
  end

  // Counter register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 4'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // Outside the answer cycle the lines show the inverse.
  assign adc_done = (cnt == 4'h1);
  assign adc_value = adc_done ? value_in : ~value_in;
  assign adc_match = adc_done ? match_in : ~match_in;
endmodule

// *** ascf_core_tb_top.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the scan, compare-hit and format block.
module ascf_core_tb_top;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [4:0] adc_channel, ch_seen;
  logic adc_sample, adc_hold_discharge, adc_convert_start, charge_unit_enable;
  logic adc_done, adc_match, match_in, cu_seen;
  logic signed [15:0] adc_value, value_in;
  logic [3:0] delay_in;
  int n_mismatch, comparisons, n_samples, run_len, samp_len;

  ascf_core ascf_core_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .adc_channel(adc_channel),
    .adc_sample(adc_sample), .adc_hold_discharge(adc_hold_discharge),
    .adc_convert_start(adc_convert_start), .charge_unit_enable(charge_unit_enable),
    .adc_done(adc_done), .adc_value(adc_value), .adc_match(adc_match), .irq(irq));
  ascf_fe_model ascf_fe_model_inst (.hclk(hclk), .hresetn(hresetn), .adc_sample(adc_sample),
    .adc_convert_start(adc_convert_start), .value_in(value_in), .match_in(match_in),
    .delay_in(delay_in), .adc_done(adc_done), .adc_value(adc_value), .adc_match(adc_match));

  // Counts and times samples; notes channel and charge unit.
  always @(posedge hclk) begin
    if (adc_done) cu_seen <= charge_unit_enable;
    if (adc_sample && run_len == 0) begin
      n_samples <= n_samples + 1;
      ch_seen <= adc_channel;
    end
    if (adc_sample) run_len <= run_len + 1;
    else if (run_len != 0) begin
      samp_len <= run_len;
      run_len <= 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison.
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waits for hready at a rising edge; a long wait ends the run.
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        n_mismatch++;
        finish_test();
      end
      @(posedge hclk);
    end
  endtask

  // One word transfer: address phase, then data phase.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] f, input logic r, input logic [1:0] cm,
                                     input logic [7:0] dv, input logic [4:0] sp);
    return {3'h0, sp, dv, 2'h0, cm, 1'b0, r, f, 7'h0, 1'b1};
  endfunction
  // Start, 12-bit integer, compare mode 0, one period of two clocks.
  localparam logic [31:0] CTL_DEF = 32'h0100_0401;

  // Clears status, starts a scan and polls for the done flag.
  task automatic run_scan(input logic [31:0] c, input logic signed [15:0] v, input logic m);
    int i;
    value_in <= v;
    match_in <= m;
    ahb(1'b1, ascf_pkg::ADDR_STATUS, 32'h7);
    ahb(1'b1, ascf_pkg::ADDR_CONTROL, c);
    for (i = 0; i < 100; i++) begin
      ahb(1'b0, ascf_pkg::ADDR_STATUS, 32'h0);
      if (rd[ascf_pkg::ST_DONE] === 1'b1) break;
    end
    if (i == 100) begin
      n_mismatch++;
      finish_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_regs();
    logic [7:0] ad[6];
    logic [15:0] im[6];
    ad = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    im = '{16'hffff, 16'h0003, 16'hffff, 16'h7c03, 16'hffff, 16'h0003};
    for (int k = 0; k < 6; k++) begin
      ahb(1'b0, ad[k], 32'h0);
      check("reset value", rd[15:0], 16'h0000);
      ahb(1'b1, ad[k], 32'hffff_ffff);
      ahb(1'b0, ad[k], 32'h0);
      check("implemented bits", rd[15:0], im[k]);
      ahb(1'b1, ad[k], 32'h0);
    end
    ahb(1'b0, 8'h3c, 32'h0);
    check("unmapped read", rd, 32'h0);
  endtask

  task automatic t_timing();
    logic [7:0] dv[2];
    logic [4:0] sp[2];
    dv = '{8'h02, 8'h00};
    sp = '{5'h03, 5'h00};
    ahb(1'b1, ascf_pkg::ADDR_SCAN_LOW, 32'h8);
    for (int k = 0; k < 2; k++) begin
      run_scan(ctl(2'h0, 1'b1, 2'h0, dv[k], sp[k]), 16'sh0001, 1'b0);
      check("sample length", samp_len, ((sp[k] == 0) ? 1 : sp[k]) * 2 * (dv[k] + 1));
      check("channel", ch_seen, 5'h03);
    end
  endtask

  task automatic t_channels();
    int n0;
    n0 = n_samples;
    ahb(1'b1, ascf_pkg::ADDR_SCAN_HIGH, 32'h0401);
    run_scan(CTL_DEF, 16'sh0001, 1'b0);
    check("scan count", n_samples - n0, 3);
    check("last channel", ch_seen, 5'h1a);
    ahb(1'b1, ascf_pkg::ADDR_SCAN_HIGH, 32'h0);
  endtask

  task automatic t_charge_hit();
    ahb(1'b1, ascf_pkg::ADDR_CONN_LOW, 32'h0);
    run_scan(CTL_DEF, 16'sh0001, 1'b0);
    check("charge unit off", cu_seen, 1'b0);
    ahb(1'b0, ascf_pkg::ADDR_HIT_LOW, 32'h0);
    check("no match no hit", rd[15:0], 16'h0);
    ahb(1'b1, ascf_pkg::ADDR_CONN_LOW, 32'h8);
    run_scan(CTL_DEF, 16'sh0001, 1'b1);
    check("charge unit on", cu_seen, 1'b1);
    ahb(1'b0, ascf_pkg::ADDR_HIT_LOW, 32'h0);
    check("match hit", rd[15:0], 16'h0008);
    ahb(1'b1, ascf_pkg::ADDR_SCAN_LOW, 32'h0);
    ahb(1'b1, ascf_pkg::ADDR_SCAN_HIGH, 32'h2);
    ahb(1'b1, ascf_pkg::ADDR_CONN_HIGH, 32'h2);
    run_scan(ctl(2'h0, 1'b1, ascf_pkg::CM_OUTSIDE, 8'h0, 5'h1), 16'sh0001, 1'b0);
    check("charge unit ch17", cu_seen, 1'b1);
    ahb(1'b0, ascf_pkg::ADDR_HIT_HIGH, 32'h0);
    check("outside mode hit", rd[15:0], 16'h0002);
    ahb(1'b1, ascf_pkg::ADDR_SCAN_HIGH, 32'h0);
    ahb(1'b1, ascf_pkg::ADDR_SCAN_LOW, 32'h1);
  endtask

  task automatic t_formats();
    int vals[5];
    int b, c, lo, hi;
    logic [15:0] e;
    vals = '{4095, 5000, -1, -5000, 1000};
    for (int r = 0; r < 2; r++) for (int f = 0; f < 4; f++) for (int k = 0; k < 5; k++) begin
      b = r ? 12 : 10;
      hi = (1 << b) - 1;
      lo = (f % 2) ? -(1 << b) : 0;
      c = (vals[k] > hi) ? hi : ((vals[k] < lo) ? lo : vals[k]);
      e = (f < 2) ? c : ((f == 2) ? c << (16 - b) : c << (15 - b));
      run_scan(ctl(f[1:0], r[0], 2'h0, 8'h0, 5'h1), vals[k][15:0], 1'b0);
      ahb(1'b0, ascf_pkg::ADDR_RESULT, 32'h0);
      check("formatted result", rd[15:0], e);
    end
  endtask

  task automatic t_irq_empty();
    int n0;
    ahb(1'b1, ascf_pkg::ADDR_MASK, 32'h4);
    run_scan(CTL_DEF, 16'sh0001, 1'b0);
    check("irq raised", irq, 1'b1);
    ahb(1'b1, ascf_pkg::ADDR_STATUS, 32'h4);
    repeat (2) @(posedge hclk);
    check("irq cleared", irq, 1'b0);
    ahb(1'b1, ascf_pkg::ADDR_MASK, 32'h0);
    ahb(1'b1, ascf_pkg::ADDR_SCAN_LOW, 32'h0);
    n0 = n_samples;
    run_scan(CTL_DEF, 16'sh0001, 1'b0);
    check("irq masked", irq, 1'b0);
    check("empty map no sample", n_samples - n0, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and main sequence.
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, match_in} = '0;
    hsize = 3'h2;
    value_in = 16'sh0;
    delay_in = 4'h3;
    ch_seen = 5'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_timing();
    delay_in <= 4'h1;
    t_channels();
    delay_in <= 4'h6;
    t_charge_hit();
    t_formats();
    t_irq_empty();
    finish_test();
  end
endmodule
